/* core/tmc_channel_ctl.sv */
// Timer channel 0 mode control with AXI4-Lite register access
`timescale 1ns/1ps
module tmc_channel_ctl
    import tmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input tmc_timer_in_t timer_in,
    output tmc_chan_out_t chan_out
);

    logic [7:0] ctl_reg;
    logic [TMC_CV_W-1:0] cv_preload_reg;
    logic [TMC_CV_W-1:0] cv_active_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic prepare_reg;
    logic prepare_next;
    logic match_prev_reg;
    logic pwm_prev_reg;
    logic fast_hold_reg;
    logic [2:0] sel;
    logic [1:0] dir;
    logic match;
    logic match_rise;
    logic pwm_level;
    logic pwm_mode;
    logic do_write;
    logic wr_ctl;
    logic wr_cv;
    logic filt_level;
    logic [31:0] rd_word;
    logic rd_hit;

    assign sel = ctl_reg[TMC_SEL_MSB:TMC_SEL_LSB];
    assign dir = ctl_reg[TMC_DIR_MSB:TMC_DIR_LSB];

    // ==================================================
    // Write channel: address and data taken in either order
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_ctl = do_write && (awaddr_reg == TMC_ADDR_CTL);
    assign wr_cv = do_write && (awaddr_reg == TMC_ADDR_CV);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_reg && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TMC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_ctl || wr_cv) ? TMC_RESP_OKAY : TMC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==================================================
    // Mode-control register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_reg <= TMC_CTL_RESET;
        end else if (wr_ctl && wstrb_reg[0]) begin
            ctl_reg[TMC_FILT_MSB:TMC_FILT_LSB + 0] <=
                wdata_reg[TMC_FILT_MSB:TMC_FILT_LSB];
            ctl_reg[TMC_SHADOW_BIT] <= wdata_reg[TMC_SHADOW_BIT];
            ctl_reg[TMC_FAST_BIT] <= wdata_reg[TMC_FAST_BIT];
            if (!timer_in.channel_enable_bit) begin
                ctl_reg[TMC_DIR_MSB:TMC_DIR_LSB] <=
                    wdata_reg[TMC_DIR_MSB:TMC_DIR_LSB];
            end
        end
    end

    // ==================================================
    // Compare value with optional shadow copy
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cv_preload_reg <= TMC_CV_RESET;
        end else if (wr_cv) begin
            if (wstrb_reg[0]) begin
                cv_preload_reg[7:0] <= wdata_reg[7:0];
            end
            if (wstrb_reg[1]) begin
                cv_preload_reg[15:8] <= wdata_reg[15:8];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cv_active_reg <= TMC_CV_RESET;
        end else if (!ctl_reg[TMC_SHADOW_BIT]
                     || timer_in.update_event) begin
            cv_active_reg <= cv_preload_reg;
        end
    end

    // ==================================================
    // Read channel
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            TMC_ADDR_CTL: rd_word[7:0] = ctl_reg;
            TMC_ADDR_CV: rd_word[TMC_CV_W-1:0] = cv_preload_reg;
            TMC_ADDR_STAT: begin
                rd_word[TMC_CV_W-1:0] = cv_active_reg;
                rd_word[TMC_STAT_PREP_BIT] = prepare_reg;
                rd_word[TMC_STAT_FILT_BIT] = filt_level;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TMC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? TMC_RESP_OKAY : TMC_RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ==================================================
    // Compare logic
    assign match = (timer_in.counter_value == cv_active_reg);
    assign match_rise = match && !match_prev_reg;
    assign pwm_mode = (sel == TMC_SEL_PWM0) || (sel == TMC_SEL_PWM1);

    always_comb begin
        if (timer_in.count_down) begin
            pwm_level = !(timer_in.counter_value > cv_active_reg);
        end else begin
            pwm_level = timer_in.counter_value < cv_active_reg;
        end
        if (sel == TMC_SEL_PWM1) begin
            pwm_level = !pwm_level;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Start as matched so leaving reset is not a fresh match
            match_prev_reg <= 1'b1;
            pwm_prev_reg <= 1'b0;
        end else begin
            match_prev_reg <= match;
            pwm_prev_reg <= pwm_level;
        end
    end

    // Trigger edge forces the up-count post-match level (PWM0 low, PWM1 high) until the comparison moves
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_hold_reg <= 1'b0;
        end else if (pwm_mode && ctl_reg[TMC_FAST_BIT]
                     && timer_in.trigger_edge) begin
            fast_hold_reg <= 1'b1;
        end else if (!pwm_mode || pwm_level != pwm_prev_reg) begin
            fast_hold_reg <= 1'b0;
        end
    end

    always_comb begin
        prepare_next = prepare_reg;
        case (sel)
            TMC_SEL_TIMING: prepare_next = prepare_reg;
            TMC_SEL_SET: begin
                if (match) begin
                    prepare_next = 1'b1;
                end
            end
            TMC_SEL_CLEAR: begin
                if (match) begin
                    prepare_next = 1'b0;
                end
            end
            TMC_SEL_TOGGLE: begin
                if (match_rise) begin
                    prepare_next = !prepare_reg;
                end
            end
            TMC_SEL_LOW: prepare_next = 1'b0;
            TMC_SEL_HIGH: prepare_next = 1'b1;
            TMC_SEL_PWM0, TMC_SEL_PWM1: begin
                if (ctl_reg[TMC_FAST_BIT] && timer_in.trigger_edge) begin
                    prepare_next = (sel == TMC_SEL_PWM1);
                end else if (!fast_hold_reg) begin
                    prepare_next = pwm_level;
                end
            end
            default: prepare_next = prepare_reg;
        endcase
        if (dir != TMC_DIR_OUTPUT) begin
            prepare_next = prepare_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prepare_reg <= 1'b0;
        end else begin
            prepare_reg <= prepare_next;
        end
    end

    // ==================================================
    // Input filter on the capture line
    tmc_input_filter u_filter (
        .clk(clk),
        .rst_b(rst_b),
        .setting(ctl_reg[TMC_FILT_MSB:TMC_FILT_LSB]),
        .sample_in(timer_in.capture_input_line),
        .level_out(filt_level)
    );

    // ==================================================
    // Registered channel outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chan_out <= '0;
        end else begin
            chan_out.compare_prepare_signal <= prepare_next;
            chan_out.primary_channel_output <= timer_in.channel_enable_bit
                && (dir == TMC_DIR_OUTPUT)
                && (prepare_next ^ timer_in.output_polarity_bit);
            chan_out.complementary_channel_output <=
                timer_in.channel_enable_bit && (dir == TMC_DIR_OUTPUT)
                && (!prepare_next
                    ^ timer_in.complementary_polarity_bit);
            chan_out.filtered_edge_input <=
                (dir == TMC_DIR_INPUT) && filt_level;
            chan_out.compare_match <= (dir == TMC_DIR_OUTPUT) && match_rise;
        end
    end

endmodule

/* core/tmc_input_filter.sv */
// Digital input filter for the capture input line
`timescale 1ns/1ps
module tmc_input_filter
    import tmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] setting,
    input wire logic sample_in,
    output logic level_out
);

    logic [4:0] div_reg;
    logic [3:0] run_reg;
    logic strobe;

    assign strobe = (div_reg == 5'h00);

    // ==================================================
    // Sample rate divider
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= 5'h00;
        end else if (strobe) begin
            div_reg <= TMC_FILT_DIV[setting];
        end else begin
            div_reg <= div_reg - 5'h01;
        end
    end

    // ==================================================
    // Count consecutive differing samples before taking the level
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_reg <= 4'h0;
            level_out <= 1'b0;
        end else if (setting == TMC_FILT_OFF) begin
            run_reg <= 4'h0;
            level_out <= sample_in;
        end else if (strobe) begin
            if (sample_in == level_out) begin
                run_reg <= 4'h0;
            end else if (run_reg + 4'h1 >= TMC_FILT_COUNT[setting]) begin
                run_reg <= 4'h0;
                level_out <= sample_in;
            end else begin
                run_reg <= run_reg + 4'h1;
            end
        end
    end

endmodule

/* core/tmc_pkg.sv */
// Constants and types for the timer channel 0 mode-control block
// Function
// - Timing code holds prepare signal steady
// - Set code drives prepare high on match
// - Clear code drives prepare low on match
// - Toggle code inverts prepare on each match
// - Codes 100/101 force prepare low/high
// - PWM mode0 level from counter versus compare
// - PWM mode1 is the inverse of mode0
// - PWM level changes only on real transitions
// - Prepare active high; polarity bits shape outputs
// - Shadow enable loads compare value on update
// - Fast enable: trigger edge acts as match (PWM modes only; forces the up-count post-match level in both directions)
// - Direction field: output, input, reserved codes
// - Direction field writable only while disabled
// - Input filter needs consecutive equal samples
package tmc_pkg;

    // ==================================================
    // Register map
    localparam logic [7:0] TMC_ADDR_CTL = 8'h18;
    localparam logic [7:0] TMC_ADDR_CV = 8'h40;
    localparam logic [7:0] TMC_ADDR_STAT = 8'h44;
    localparam logic [7:0] TMC_CTL_RESET = 8'h00;
    localparam logic [15:0] TMC_CV_RESET = 16'h0000;
    localparam logic [1:0] TMC_RESP_OKAY = 2'h0;
    localparam logic [1:0] TMC_RESP_SLVERR = 2'h2;

    // ==================================================
    // Field positions in the mode-control and status registers; compare value width
    localparam int TMC_SEL_LSB = 4;
    localparam int TMC_SEL_MSB = 6;
    localparam int TMC_SHADOW_BIT = 3;
    localparam int TMC_FAST_BIT = 2;
    localparam int TMC_DIR_LSB = 0;
    localparam int TMC_DIR_MSB = 1;
    localparam int TMC_FILT_LSB = 4;
    localparam int TMC_FILT_MSB = 7;
    localparam int TMC_CV_W = 16;
    localparam int TMC_STAT_PREP_BIT = 16;
    localparam int TMC_STAT_FILT_BIT = 17;

    // ==================================================
    // Modes
    localparam logic [2:0] TMC_SEL_TIMING = 3'h0;
    localparam logic [2:0] TMC_SEL_SET = 3'h1;
    localparam logic [2:0] TMC_SEL_CLEAR = 3'h2;
    localparam logic [2:0] TMC_SEL_TOGGLE = 3'h3;
    localparam logic [2:0] TMC_SEL_LOW = 3'h4;
    localparam logic [2:0] TMC_SEL_HIGH = 3'h5;
    localparam logic [2:0] TMC_SEL_PWM0 = 3'h6;
    localparam logic [2:0] TMC_SEL_PWM1 = 3'h7;
    localparam logic [1:0] TMC_DIR_OUTPUT = 2'h0;
    localparam logic [1:0] TMC_DIR_INPUT = 2'h1;

    // ==================================================
    // Filter table: consecutive samples and sample divider minus one
    localparam logic [15:0][3:0] TMC_FILT_COUNT = {
        4'h8, 4'h6, 4'h5, 4'h8, 4'h6, 4'h5, 4'h8, 4'h6,
        4'h8, 4'h6, 4'h8, 4'h6, 4'h8, 4'h4, 4'h2, 4'h0};
    localparam logic [15:0][4:0] TMC_FILT_DIV = {
        5'h1f, 5'h1f, 5'h1f, 5'h0f, 5'h0f, 5'h0f, 5'h07, 5'h07,
        5'h03, 5'h03, 5'h01, 5'h01, 5'h00, 5'h00, 5'h00, 5'h00};
    localparam logic [3:0] TMC_FILT_OFF = 4'h0;

    // ==================================================
    // Carriers
    typedef struct packed {
        logic [TMC_CV_W-1:0] counter_value;
        logic count_down;
        logic update_event;
        logic trigger_edge;
        logic channel_enable_bit;
        logic one_shot_select;
        logic output_polarity_bit;
        logic complementary_polarity_bit;
        logic capture_input_line;
    } tmc_timer_in_t;

    typedef struct packed {
        logic compare_prepare_signal;
        logic primary_channel_output;
        logic complementary_channel_output;
        logic filtered_edge_input;
        logic compare_match;
    } tmc_chan_out_t;

endpackage

/* verif/timer_channel0_mode_control_test.sv */
// Self-checking bench for the timer channel mode-control block
`timescale 1ns/1ps
module timer_channel0_mode_control_test;
    import tmc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0;
    logic [7:0] s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic late = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    tmc_timer_in_t ti = '0;
    tmc_chan_out_t co;
    int compares = 0;
    int miscompares = 0;
    int cyc = 0;
    int hits = 0;
    int h0;
    // PWM table: select, down, counter, expected prepare
    logic [27:0] pt [8] = '{28'h6000051, 28'h6000100, 28'h6100200,
        28'h6100101, 28'h7000050, 28'h7000201, 28'h7100201, 28'h7100050};
    tmc_channel_ctl dut_u (.clk, .rst_b, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .timer_in(ti), .chan_out(co));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Counts compare match pulses as they stand
    always @(posedge clk) begin
        if (co.compare_match === 1'b1) hits <= hits + 1;
    end
    // ==========================================
    // Bus and check helpers
    task final_report;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            final_report();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !late;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
        end while (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rdw(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !late;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
        end while (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task md(input logic [2:0] s, input logic [3:0] lo);
        wr(TMC_ADDR_CTL, {24'h0, 1'b0, s, lo});
        tk(3);
    endtask
    task cnt(input logic [15:0] v);
        ti.counter_value <= v;
        tk(3);
    endtask
    task prep(input logic e, input string m);
        chk(co.compare_prepare_signal, e, m);
    endtask
    // ==========================================
    // Scenarios
    task t_regs;
        rdw(TMC_ADDR_CTL);
        chk(rd, 32'h0, "ctl reset");
        prep(1'b0, "prepare reset");
        s_axi_wstrb <= 4'h1;
        wr(TMC_ADDR_CV, 32'h0000_2233);
        s_axi_wstrb <= 4'hf;
        rdw(TMC_ADDR_CV);
        chk(rd, 32'h33, "cv byte lane");
        wr(TMC_ADDR_CV, 32'hffff0010);
        rdw(TMC_ADDR_CV);
        chk(rd, 32'h10, "cv readback");
        late = 1'b1;
        wr(8'h04, 32'h1);
        chk(rsp, TMC_RESP_SLVERR, "unmapped write");
        rdw(8'h04);
        chk(rsp, TMC_RESP_SLVERR, "unmapped read resp");
        chk(rd, 32'h0, "unmapped read data");
        late = 1'b0;
        wr(TMC_ADDR_STAT, 32'h0);
        chk(rsp, TMC_RESP_SLVERR, "status write");
        $display("t_regs done");
    endtask
    task t_modes;
        ti.channel_enable_bit <= 1'b1;
        cnt(16'h5);
        md(TMC_SEL_HIGH, 4'h0);
        prep(1'b1, "force high");
        chk(co.primary_channel_output, 1'b1, "primary");
        ti.output_polarity_bit <= 1'b1;
        ti.complementary_polarity_bit <= 1'b1;
        tk(3);
        chk(co.primary_channel_output, 1'b0, "primary inv");
        chk(co.complementary_channel_output, 1'b1, "compl inv");
        ti.output_polarity_bit <= 1'b0;
        ti.complementary_polarity_bit <= 1'b0;
        md(TMC_SEL_TIMING, 4'h0);
        cnt(16'h10);
        prep(1'b1, "timing holds");
        md(TMC_SEL_CLEAR, 4'h0);
        prep(1'b0, "clear on match");
        md(TMC_SEL_SET, 4'h0);
        prep(1'b1, "set on match");
        md(TMC_SEL_LOW, 4'h0);
        prep(1'b0, "force low");
        cnt(16'h5);
        md(TMC_SEL_TOGGLE, 4'h0);
        h0 = hits;
        cnt(16'h10);
        prep(1'b1, "toggle one");
        chk(hits - h0, 32'h1, "one match pulse");
        cnt(16'h5);
        prep(1'b1, "toggle hold");
        cnt(16'h10);
        prep(1'b0, "toggle two");
        for (int i = 0; i < 8; i++) begin
            md(TMC_SEL_TIMING, 4'h0);
            ti.count_down <= pt[i][20];
            cnt(pt[i][19:4]);
            md(pt[i][26:24], 4'h8);
            prep(pt[i][0], "pwm table");
        end
        ti.count_down <= 1'b0;
        $display("t_modes done");
    endtask
    task t_fast_shadow;
        md(TMC_SEL_TIMING, 4'h0);
        cnt(16'h5);
        md(TMC_SEL_PWM0, 4'hc);
        prep(1'b1, "pwm start");
        ti.trigger_edge <= 1'b1;
        tk(1);
        ti.trigger_edge <= 1'b0;
        tk(3);
        prep(1'b0, "fast trigger");
        cnt(16'h20);
        cnt(16'h5);
        prep(1'b1, "fast release");
        md(TMC_SEL_TIMING, 4'h0);
        cnt(16'h8);
        md(TMC_SEL_PWM0, 4'h8);
        wr(TMC_ADDR_CV, 32'h4);
        tk(3);
        prep(1'b1, "shadow held");
        ti.update_event <= 1'b1;
        tk(1);
        ti.update_event <= 1'b0;
        tk(3);
        prep(1'b0, "shadow loaded");
        rdw(TMC_ADDR_STAT);
        chk(rd[15:0], 16'h4, "active value");
        $display("t_fast_shadow done");
    endtask
    task t_dir;
        wr(TMC_ADDR_CTL, 32'h1);
        rdw(TMC_ADDR_CTL);
        chk(rd, 32'h0, "dir locked");
        ti.channel_enable_bit <= 1'b0;
        wr(TMC_ADDR_CTL, 32'h1);
        rdw(TMC_ADDR_CTL);
        chk(rd, 32'h1, "dir written");
        ti.capture_input_line <= 1'b1;
        tk(4);
        chk(co.filtered_edge_input, 1'b1, "input path");
        ti.capture_input_line <= 1'b0;
        wr(TMC_ADDR_CTL, 32'h11);
        tk(4);
        ti.capture_input_line <= 1'b1;
        tk(1);
        ti.capture_input_line <= 1'b0;
        tk(6);
        chk(co.filtered_edge_input, 1'b0, "glitch kept out");
        ti.capture_input_line <= 1'b1;
        tk(8);
        chk(co.filtered_edge_input, 1'b1, "level accepted");
        wr(TMC_ADDR_CTL, 32'h2);
        tk(3);
        chk(co.filtered_edge_input, 1'b0, "reserved dir");
        wr(TMC_ADDR_CTL, 32'h52);
        tk(3);
        prep(1'b0, "prepare frozen");
        wr(TMC_ADDR_CTL, 32'h50);
        tk(3);
        prep(1'b1, "output mode again");
        $display("t_dir done");
    endtask
    initial begin
        tk(8);
        rst_b <= 1'b1;
        tk(1);
        t_regs;
        t_modes;
        t_fast_shadow;
        t_dir;
        final_report;
    end
endmodule

/* verif/tmc_channel_ctl_properties.sv */
// Bus handshake and channel output checks for the mode-control block
`timescale 1ns/1ps
module tmc_channel_ctl_properties
    import tmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire tmc_timer_in_t timer_in,
    input wire tmc_chan_out_t chan_out
);
    // ==========================================
    // Handshake sequences
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence aw_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_w_answer: assert property (aw_take |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    chk_r_answer: assert property (ar_take |=> s_axi_rvalid)
        else $error("read data late");
    chk_aw_drop: assert property (aw_take |=> !s_axi_awready)
        else $error("awready stayed high after take");
    chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready high while read pending");
    chk_err_zero: assert property (s_axi_rvalid &&
        s_axi_rresp == TMC_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    chk_out_gate: assert property (
        !timer_in.channel_enable_bit |=> !chan_out.primary_channel_output
        && !chan_out.complementary_channel_output)
        else $error("outputs active while disabled");
    chk_match_pulse: assert property (
        chan_out.compare_match |=> !chan_out.compare_match)
        else $error("match longer than one cycle");
endmodule
bind tmc_channel_ctl tmc_channel_ctl_properties chk_u (.clk, .rst_b,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .timer_in, .chan_out);
